// ===== hw/npr_pkg.sv
package npr_pkg;
    // ==========================================================
    // Command codes
    // ==========================================================
    localparam logic [7:0] CMD_MAIN_A = 8'h00;
    localparam logic [7:0] CMD_MAIN_B = 8'h01;
    localparam logic [7:0] CMD_SPARE = 8'h50;
    localparam logic [7:0] CMD_PROG = 8'h80;
    localparam logic [7:0] CMD_PROG_GO = 8'h10;
    localparam logic [7:0] CMD_ERASE = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_IDENT = 8'h90;
    localparam logic [7:0] ADDR_IDENT = 8'h00;

    // ==========================================================
    // Geometry
    // ==========================================================
    localparam int PAGE_BYTES = 528;
    localparam int PAGE_WORDS = 264;
    localparam int IDENT_READS = 2;
    localparam int HALF_COLS = 256;
    localparam int SPARE_START_X8 = 512;
    localparam int SPARE_START_X16 = 256;
    localparam logic [7:0] SPARE_MASK_X8 = 8'h0F;
    localparam logic [7:0] SPARE_MASK_X16 = 8'h07;
    localparam logic [15:0] UPPER_MASK = 16'h00FF;
    localparam logic [2:0] ADDR_CYCLES = 3'h3;
    localparam logic [1:0] ERASE_ADDR_CYCLES = 2'h2;
    localparam int STATUS_FAIL_BIT = 0;
    localparam int STATUS_READY_BIT = 6;

    // ==========================================================
    // Timing (20 MHz clock)
    // ==========================================================
    localparam int CLK_NS = 50;
    localparam int STROBE_LOW_NS = 25;
    localparam int STROBE_HIGH_NS = 25;
    localparam int BUSY_SETTLE_NS = 100;
    localparam int STROBE_LOW_CYC =
        (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_HIGH_CYC =
        (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUSY_SETTLE_CYC =
        (BUSY_SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ARRAY_LOAD_TIME_US = 10;
    localparam int ARRAY_LOAD_CYC = ARRAY_LOAD_TIME_US * 1000 / CLK_NS;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        NPR_OP_READ_MAIN,
        NPR_OP_READ_UPPER,
        NPR_OP_READ_SPARE,
        NPR_OP_PROGRAM,
        NPR_OP_ERASE,
        NPR_OP_STATUS,
        NPR_OP_IDENT
    } npr_op_e;

    typedef enum logic [1:0] {
        NPR_PTR_MAIN,
        NPR_PTR_UPPER,
        NPR_PTR_SPARE
    } npr_ptr_e;

    typedef struct packed {
        npr_op_e op;
        logic [7:0] column;
        logic [15:0] row;
        logic [9:0] count;
    } npr_req_s;

    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic output_strobe_n;
        logic spare_sel_n;
    } npr_pins_s;
endpackage

// ===== hw/npr_strobe.sv
`timescale 1ns/10ps
// Generates one low-then-high strobe for a bus cycle
module npr_strobe (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    output logic o_low,
    output logic o_done
);
    import npr_pkg::*;

    logic [3:0] cnt;
    logic phase;
    logic active;

    // ==========================================================
    // Low phase then high phase, each at least one clock
    // ==========================================================
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 4'h0;
            phase <= 1'b0;
            active <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (!active) begin
                if (i_start) begin
                    active <= 1'b1;
                    phase <= 1'b0;
                    cnt <= 4'(STROBE_LOW_CYC - 1);
                end
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (!phase) begin
                phase <= 1'b1;
                cnt <= 4'(STROBE_HIGH_CYC - 1);
            end else begin
                active <= 1'b0;
                o_done <= 1'b1;
            end
        end
    end

    assign o_low = active && !phase;
endmodule

// ===== hw/npr_timer.sv
`timescale 1ns/10ps
// Down counter for waits measured in clocks
module npr_timer #(
    parameter int WIDTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_value,
    output logic o_zero
);
    logic [WIDTH-1:0] cnt;

    // ==========================================================
    // Count down; o_zero when expired
    // ==========================================================
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= '0;
        end else if (i_load) begin
            cnt <= i_value;
        end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
        end
    end

    assign o_zero = (cnt == '0) && !i_load;
endmodule

// ===== hw/npr_host.sv
`timescale 1ns/10ps
module npr_host (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_x16,
    input wire logic i_req_valid,
    input npr_pkg::npr_req_s i_req,
    output logic o_req_ready,
    input wire logic [15:0] i_wr_data,
    output logic o_wr_take,
    output logic [15:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_done,
    output logic o_fail,
    output logic o_bad_block,
    output logic o_ce_n,
    output logic o_cle,
    output logic o_ale,
    output logic o_we_n,
    output logic o_output_strobe_n,
    output logic o_spare_sel_n,
    output logic [15:0] o_io,
    output logic o_io_oe,
    input wire logic [15:0] i_io,
    input wire logic i_ready_busy_n
);
    import npr_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    typedef enum logic [3:0] {
        ST_IDLE, ST_PTR, ST_CMD, ST_ADDR, ST_WAIT_BUSY, ST_WAIT_READY,
        ST_READ, ST_WRITE, ST_CONFIRM, ST_STAT_CMD, ST_STAT_READ
    } npr_state_e;

    npr_state_e state;
    npr_req_s req;
    npr_ptr_e dev_ptr;
    logic ptr_known;
    logic [2:0] addr_idx;
    logic [9:0] left;
    logic [1:0] sub;
    logic stb_start;
    logic stb_low;
    logic stb_done;
    logic tmr_load;
    logic [15:0] tmr_value;
    logic tmr_zero;

    npr_strobe u_strobe (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_start(stb_start),
        .o_low(stb_low),
        .o_done(stb_done)
    );

    npr_timer #(.WIDTH(16)) u_timer (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_load(tmr_load),
        .i_value(tmr_value),
        .o_zero(tmr_zero)
    );

    // ==========================================================
    // Decoding of the request
    // ==========================================================
    wire is_read = (req.op == NPR_OP_READ_MAIN) ||
                   (req.op == NPR_OP_READ_UPPER) ||
                   (req.op == NPR_OP_READ_SPARE);
    wire npr_ptr_e want_ptr =
        (req.op == NPR_OP_READ_SPARE) ? NPR_PTR_SPARE :
        (req.op == NPR_OP_READ_UPPER && !i_x16) ? NPR_PTR_UPPER :
        NPR_PTR_MAIN;
    wire [7:0] ptr_cmd = (want_ptr == NPR_PTR_SPARE) ? CMD_SPARE :
                         (want_ptr == NPR_PTR_UPPER) ? CMD_MAIN_B :
                         CMD_MAIN_A;
    // 01h always reissued; others only when changed or not known
    wire need_ptr = !ptr_known || (dev_ptr != want_ptr) ||
                    (want_ptr == NPR_PTR_UPPER);
    wire uses_ptr = is_read || (req.op == NPR_OP_PROGRAM);
    wire [7:0] main_cmd =
        (req.op == NPR_OP_PROGRAM) ? CMD_PROG :
        (req.op == NPR_OP_ERASE) ? CMD_ERASE :
        (req.op == NPR_OP_STATUS) ? CMD_STATUS : CMD_IDENT;
    wire [7:0] col_spare = req.column &
                           (i_x16 ? SPARE_MASK_X16 : SPARE_MASK_X8);
    wire [7:0] col = (want_ptr == NPR_PTR_SPARE) ? col_spare : req.column;
    // First column of the read, so the word count stops at page end
    wire [9:0] start_col =
        (want_ptr == NPR_PTR_SPARE) ?
            10'(i_x16 ? SPARE_START_X16 : SPARE_START_X8) + 10'(col) :
        (want_ptr == NPR_PTR_UPPER) ? 10'(HALF_COLS) + 10'(col) :
        10'(col);
    wire [2:0] n_addr = (req.op == NPR_OP_ERASE) ? 3'(ERASE_ADDR_CYCLES) :
                        (req.op == NPR_OP_IDENT) ? 3'h1 : ADDR_CYCLES;
    wire [7:0] addr_byte =
        (req.op == NPR_OP_IDENT) ? ADDR_IDENT :
        (req.op == NPR_OP_ERASE) ?
            ((addr_idx == 3'h0) ? req.row[7:0] : req.row[15:8]) :
        (addr_idx == 3'h0) ? col :
        (addr_idx == 3'h1) ? req.row[7:0] : req.row[15:8];
    // upper lines zero in command and address
    wire [15:0] cmd_bus = {8'h00, (state == ST_PTR) ? ptr_cmd :
                          (state == ST_CONFIRM) ?
                          ((req.op == NPR_OP_ERASE) ? CMD_ERASE_GO :
                           CMD_PROG_GO) :
                          (state == ST_STAT_CMD) ? CMD_STATUS :
                          (state == ST_ADDR) ? addr_byte : main_cmd};
    wire [15:0] wr_bus = i_x16 ? i_wr_data : (i_wr_data & UPPER_MASK);
    wire [15:0] rd_bus = i_x16 ? i_io : (i_io & UPPER_MASK);
    wire fail_bit = i_io[STATUS_FAIL_BIT];
    wire ready_bit = i_io[STATUS_READY_BIT];
    wire [9:0] page_len = 10'(i_x16 ? PAGE_WORDS : PAGE_BYTES);

    // ==========================================================
    // Sequencer
    // ==========================================================
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            req <= '0;
            dev_ptr <= NPR_PTR_MAIN;
            ptr_known <= 1'b0;
            addr_idx <= 3'h0;
            left <= 10'h000;
            sub <= 2'h0;
            stb_start <= 1'b0;
            tmr_load <= 1'b0;
            tmr_value <= 16'h0000;
            o_req_ready <= 1'b0;
            o_wr_take <= 1'b0;
            o_rd_data <= 16'h0000;
            o_rd_valid <= 1'b0;
            o_done <= 1'b0;
            o_fail <= 1'b0;
            o_bad_block <= 1'b0;
            o_ce_n <= 1'b1;
            o_cle <= 1'b0;
            o_ale <= 1'b0;
            o_we_n <= 1'b1;
            o_output_strobe_n <= 1'b1;
            o_spare_sel_n <= 1'b1;
            o_io <= 16'h0000;
            o_io_oe <= 1'b0;
        end else begin
            stb_start <= 1'b0;
            tmr_load <= 1'b0;
            o_wr_take <= 1'b0;
            o_rd_valid <= 1'b0;
            o_done <= 1'b0;
            o_req_ready <= (state == ST_IDLE);
            // Strobes follow the strobe timer's low phase
            o_we_n <= !(stb_low && (state inside {ST_PTR, ST_CMD,
                        ST_ADDR, ST_WRITE, ST_CONFIRM, ST_STAT_CMD}));
            o_output_strobe_n <= !(stb_low &&
                        (state inside {ST_READ, ST_STAT_READ}));
            case (state)
                ST_IDLE: begin
                    // chip enable idles high between jobs
                    o_ce_n <= 1'b1;
                    o_io_oe <= 1'b0;
                    if (i_req_valid && o_req_ready) begin
                        req <= i_req;
                        o_req_ready <= 1'b0;
                        o_fail <= 1'b0;
                        o_bad_block <= 1'b0;
                        o_ce_n <= 1'b0;
                        addr_idx <= 3'h0;
                        state <= ST_PTR;
                    end
                end
                ST_PTR: begin
                    if (!uses_ptr || !need_ptr) begin
                        // no command when read mode holds
                        state <= is_read ? ST_ADDR : ST_CMD;
                    end else if (!stb_start && !stb_done &&
                                 !o_cle) begin
                        o_cle <= 1'b1;
                        o_io <= cmd_bus;
                        o_io_oe <= 1'b1;
                        stb_start <= 1'b1;
                    end else if (stb_done) begin
                        o_cle <= 1'b0;
                        // 00h or 50h remain in force
                        dev_ptr <= want_ptr;
                        ptr_known <= 1'b1;
                        state <= is_read ? ST_ADDR : ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (!o_cle && !stb_start) begin
                        o_cle <= 1'b1;
                        o_io <= cmd_bus;
                        o_io_oe <= 1'b1;
                        stb_start <= 1'b1;
                    end else if (stb_done) begin
                        o_cle <= 1'b0;
                        if (req.op == NPR_OP_STATUS) begin
                            ptr_known <= 1'b0;
                            state <= ST_STAT_READ;
                            stb_start <= 1'b1;
                            o_io_oe <= 1'b0;
                        end else begin
                            if (req.op == NPR_OP_IDENT) begin
                                ptr_known <= 1'b0;
                            end
                            state <= ST_ADDR;
                        end
                    end
                end
                ST_ADDR: begin
                    if (!o_ale && !stb_start) begin
                        o_ale <= 1'b1;
                        o_io <= cmd_bus;
                        o_io_oe <= 1'b1;
                        stb_start <= 1'b1;
                    end else if (stb_done) begin
                        o_ale <= 1'b0;
                        addr_idx <= addr_idx + 3'h1;
                        if (addr_idx + 3'h1 == n_addr) begin
                            o_io_oe <= 1'b0;
                            if (req.op == NPR_OP_PROGRAM) begin
                                left <= req.count;
                                state <= ST_WRITE;
                            end else if (req.op == NPR_OP_ERASE) begin
                                state <= ST_CONFIRM;
                            end else if (req.op == NPR_OP_IDENT) begin
                                left <= 10'(IDENT_READS);
                                state <= ST_READ;
                                stb_start <= 1'b1;
                            end else begin
                                left <= page_len - start_col;
                                tmr_value <= 16'(BUSY_SETTLE_CYC);
                                tmr_load <= 1'b1;
                                state <= ST_WAIT_BUSY;
                            end
                        end
                    end
                end
                ST_WAIT_BUSY: begin
                    // busy-ready goes low within settle time
                    if (tmr_zero) begin
                        tmr_value <= 16'(ARRAY_LOAD_CYC);
                        tmr_load <= 1'b1;
                        state <= ST_WAIT_READY;
                    end
                end
                ST_WAIT_READY: begin
                    // ready marks end of page load
                    if (i_ready_busy_n && !tmr_load) begin
                        if (is_read) begin
                            if (dev_ptr == NPR_PTR_UPPER) begin
                                dev_ptr <= NPR_PTR_MAIN;
                            end
                            state <= ST_READ;
                            stb_start <= 1'b1;
                        end else begin
                            state <= ST_STAT_CMD;
                        end
                    end
                end
                ST_READ: begin
                    // word taken while the strobe is low
                    // the flash turns its bus over once it rises
                    if (!o_output_strobe_n) begin
                        o_rd_data <= rd_bus;
                        o_rd_valid <= 1'b1;
                    end
                    if (stb_done) begin
                        left <= left - 10'h001;
                        if (left == 10'h001) begin
                            // one page per read; no row run-on
                            state <= ST_IDLE;
                            o_done <= 1'b1;
                            o_ce_n <= 1'b1;
                        end else begin
                            stb_start <= 1'b1;
                        end
                    end
                end
                ST_WRITE: begin
                    if (left == 10'h000) begin
                        state <= ST_CONFIRM;
                    end else if (!stb_start && sub == 2'h0) begin
                        o_io <= wr_bus;
                        o_io_oe <= 1'b1;
                        o_wr_take <= 1'b1;
                        stb_start <= 1'b1;
                        sub <= 2'h1;
                    end else if (stb_done) begin
                        sub <= 2'h0;
                        left <= left - 10'h001;
                    end
                end
                ST_CONFIRM: begin
                    if (!o_cle && !stb_start) begin
                        o_cle <= 1'b1;
                        o_io <= cmd_bus;
                        o_io_oe <= 1'b1;
                        stb_start <= 1'b1;
                    end else if (stb_done) begin
                        o_cle <= 1'b0;
                        o_io_oe <= 1'b0;
                        if (dev_ptr == NPR_PTR_UPPER) begin
                            dev_ptr <= NPR_PTR_MAIN;
                        end
                        tmr_value <= 16'(BUSY_SETTLE_CYC);
                        tmr_load <= 1'b1;
                        state <= ST_WAIT_BUSY;
                    end
                end
                ST_STAT_CMD: begin
                    if (!o_cle && !stb_start) begin
                        o_cle <= 1'b1;
                        o_io <= cmd_bus;
                        o_io_oe <= 1'b1;
                        stb_start <= 1'b1;
                    end else if (stb_done) begin
                        o_cle <= 1'b0;
                        o_io_oe <= 1'b0;
                        // status mode drops read pointer state
                        ptr_known <= 1'b0;
                        state <= ST_STAT_READ;
                        stb_start <= 1'b1;
                    end
                end
                ST_STAT_READ: begin
                    // Status taken while the strobe holds it on the bus
                    if (!o_output_strobe_n) begin
                        o_rd_data <= rd_bus;
                        o_rd_valid <= 1'b1;
                        o_fail <= fail_bit && ready_bit &&
                                  (req.op != NPR_OP_STATUS);
                        o_bad_block <= fail_bit && ready_bit &&
                                       (req.op != NPR_OP_STATUS);
                    end
                    if (stb_done) begin
                        o_done <= 1'b1;
                        o_ce_n <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

// ===== sim/npr_host_chk.sv
`timescale 1ns/10ps
// Pin checks toward the flash
module npr_host_chk (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_x16,
    input wire logic o_req_ready,
    input wire logic o_done,
    input wire logic o_ce_n,
    input wire logic o_cle,
    input wire logic o_ale,
    input wire logic o_we_n,
    input wire logic o_output_strobe_n,
    input wire logic [15:0] o_io,
    input wire logic i_ready_busy_n
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_upper_zero: assert property (
        (o_cle || o_ale) && i_x16 |-> o_io[15:8] == 8'h00) else $error("io");
    a_read_pulse: assert property (
        $fell(o_output_strobe_n) |=> $rose(o_output_strobe_n)) else $error("re");
    a_read_ready: assert property (
        !o_output_strobe_n |-> i_ready_busy_n) else $error("busy read");
    a_strobe_apart: assert property (
        !o_output_strobe_n |-> o_we_n && !o_cle) else $error("overlap");
    a_ce_held: assert property (
        !(o_we_n && o_output_strobe_n) |-> !o_ce_n) else $error("ce");
    a_write_pulse: assert property (
        $fell(o_we_n) |=> $rose(o_we_n)) else $error("we");
    a_idle_quiet: assert property (
        o_req_ready |-> o_ce_n && !o_cle && !o_ale) else $error("idle");
    a_done_once: assert property (
        o_done |=> !o_done) else $error("done");
endmodule
bind npr_host npr_host_chk npr_host_chk_i (.*);

// ===== sim/npr_flash_model.sv
`timescale 1ns/10ps
// Flash model: pointer, page load, serial out
module npr_flash_model (
    input wire logic i_ce_n,
    input wire logic i_cle,
    input wire logic i_ale,
    input wire logic i_we_n,
    input wire logic i_re_n,
    input wire logic i_x16,
    input wire logic i_fail,
    input wire logic [15:0] i_io,
    input int i_load_ns,
    output logic [15:0] o_io = 16'h0000,
    output logic o_rb = 1'b1
);
    import npr_pkg::*;
    logic [1:0] ptr = 2'h0;
    logic [7:0] cmd = 8'h00;
    logic [9:0] col;
    logic [15:0] row;
    int ac;
    // Commands and addresses latch on write strobe rise
    always @(posedge i_we_n) if (!i_ce_n && i_cle) begin
        cmd = i_io[7:0];
        ac = 0;
        col = 10'h000;
        if (cmd == CMD_MAIN_A || cmd == CMD_SPARE || cmd == CMD_MAIN_B && !i_x16)
            ptr = cmd[6] ? 2'h2 : {1'b0, cmd[0]};
        if (cmd == CMD_PROG_GO) o_rb = 1'b0;
        if (cmd == CMD_PROG_GO) o_rb <= #(i_load_ns) 1'b1;
    end else if (!i_ce_n && i_ale) begin
        // spare start from low bits only
        if (ac == 0 && ptr == 2'h2)
            col = i_x16 ? 10'h100 + i_io[2:0] : 10'h200 + i_io[3:0];
        else if (ac == 0 && cmd != CMD_IDENT) col = {1'b0, ptr[0], i_io[7:0]};
        if (ac == 1) row[7:0] = i_io[7:0];
        if (ac == 2 && !cmd[7] && !cmd[5]) begin
            o_rb = 1'b0;
            o_rb <= #(i_load_ns) 1'b1;
            ptr = ptr == 2'h1 ? 2'h0 : ptr;
        end
        ac = (ac == 2) ? 0 : ac + 1;
    end
    // next word per strobe fall; x8 upper lines float
    always @(negedge i_re_n) if (!i_ce_n) begin
        o_io = {row[5:0], col};
        if (cmd == CMD_STATUS) o_io = {8'h00, 7'h60, i_fail};
        if (cmd == CMD_IDENT) o_io = {8'h00, col[0] ? 8'h6A : 8'h3C};
        if (!i_x16) o_io[15:8] = ~o_io[15:8];
        col = col + 10'h001;
    end
    // Released bus shows no stale data
    always @(posedge i_re_n) #15 o_io = ~o_io;
endmodule

// ===== sim/test_npr_host.sv
`timescale 1ns/10ps
// Flash host bench
module test_npr_host;
    import npr_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_x16 = 1'b0;
    logic i_req_valid = 1'b0;
    npr_req_s i_req = '0;
    logic [15:0] i_wr_data = 16'h0000;
    logic fail = 1'b0;
    int load_ns = 400;
    int errors = 0;
    int tests_run = 0;
    int seed = 32'h52460745;
    logic [15:0] q[$];
    npr_op_e ops[10] = '{NPR_OP_READ_MAIN, NPR_OP_READ_UPPER, NPR_OP_READ_MAIN,
        NPR_OP_READ_SPARE, NPR_OP_READ_SPARE, NPR_OP_READ_MAIN, NPR_OP_IDENT,
        NPR_OP_READ_MAIN, NPR_OP_PROGRAM, NPR_OP_PROGRAM};
    wire [15:0] o_io, o_rd_data, fl_io, i_io;
    wire o_req_ready, o_rd_valid, o_done, o_fail, o_io_oe, rb;
    wire o_ce_n, o_cle, o_ale, o_we_n, o_output_strobe_n;
    assign i_io = o_io_oe ? o_io : fl_io;
    npr_host npr_host_i (.*, .o_bad_block(), .o_wr_take(), .o_spare_sel_n(),
        .i_ready_busy_n(rb));
    npr_flash_model npr_flash_model_i (.i_ce_n(o_ce_n), .i_cle(o_cle),
        .i_ale(o_ale), .i_we_n(o_we_n), .i_re_n(o_output_strobe_n), .i_x16,
        .i_fail(fail), .i_io(o_io), .i_load_ns(load_ns), .o_io(fl_io),
        .o_rb(rb));
    initial forever #25 i_clk = ~i_clk;
    always @(negedge i_clk) i_wr_data <= 16'($random(seed));
    task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e) errors++;
        if (g !== e) $display("Error %s expected %h seen %h", n, e, g);
    endtask
    task automatic conclude;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One request; expected words noted up to page end
    task automatic go(npr_op_e op, logic [7:0] c, logic ef);
        int n;
        int s;
        if (i_x16 && op == NPR_OP_READ_SPARE) c[7:3] = 5'h00;
        i_req = '{op, c, 16'($random(seed)), 10'h008};
        s = op == NPR_OP_READ_UPPER ? 256 + c : op != NPR_OP_READ_SPARE ? c :
            i_x16 ? 256 + c[2:0] : 512 + c[3:0];
        if (op == NPR_OP_IDENT) q = '{16'h003C, 16'h006A};
        for (n = s; op < NPR_OP_PROGRAM && n < (i_x16 ? 264 : 528); n++)
            q.push_back(i_x16 ? {i_req.row[5:0], 10'(n)} : {8'h00, 8'(n)});
        i_req_valid = 1'b1;
        for (s = 0; s < 9 && o_req_ready !== 1'b1; s++) @(negedge i_clk);
        @(negedge i_clk) i_req_valid = 1'b0;
        for (n = 0; n < 4000 && o_done !== 1'b1; n++) @(negedge i_clk);
        if (s == 9 || n == 4000) errors++;
        if (s == 9 || n == 4000) conclude;
        cmp("words_left", 16'h0000, 16'(q.size()));
        @(negedge i_clk) q.delete();
        if (op == NPR_OP_PROGRAM) cmp("fail", {15'h0, ef}, {15'h0, o_fail});
    endtask
    // Compare each read word with the oldest note while notes remain
    always @(negedge i_clk) if (o_rd_valid === 1'b1 && q.size() > 0)
        cmp("rd_data", q.pop_front(), o_rd_data);
    initial begin
        repeat (10) @(negedge i_clk);
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_clk);
        for (int x = 0; x < 2; x++) begin
            i_x16 = x[0];
            for (int k = 0; k < 10; k++) begin
                load_ns = k[0] ? 3000 : 400;
                fail = k == 9;
                go(x && k == 1 ? NPR_OP_READ_MAIN : ops[k], 8'($random(seed)),
                    fail);
            end
        end
        conclude;
    end
endmodule
